// ==== verilog/sca_top.sv ====
// strap decoding, power-up delays and system reset aggregation
`timescale 1ns/1ns
`include "sca_defines.svh"

// Notes on behaviour
// - reset low when any selected power_ok low
// - per-regulator bit includes it in reset
// - commanded-off regulators masked, masking is configurable
// - external enable after source power_ok plus delay
// - external supply good can trigger one regulator
// - any regulator power_ok routable to a pin
// - software open-drain output follows register bit
// - three-level strap picks per-regulator extra delay
// - start delay plus extra delay added
// - floating strap defaults to zero extra delay
// - buck1 strap: switch, setting 0, setting 1
// - buck2 two-level strap: setting 0 or 1
// - buck3 strap: settings 0, 1, 2
// - buck4 strap: buck 0, buck 1, linear 2
// - ldo1 strap: linear 0, switch, linear 1
// - ldo2 strap: linear high, switch low
// - shared buck1/buck2 pin uses stored buck2 choice
// - shared pin low uses dedicated low choice
// - shared ldo1/buck4 pin, type bit picks buck4
// - shared buck4: float depends on type bit
module sca_top #(
  parameter logic [`SCA_TICK_W-1:0] TICK_CYCLES = `SCA_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [`SCA_ADDR_W-1:0] reg_addr,
  input wire logic [`SCA_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SCA_DATA_W-1:0] reg_rdata,
  // regulator status and sequencing
  input wire logic [`SCA_NREG-1:0] power_ok,
  input wire logic power_up_req,
  output logic [`SCA_NREG-1:0] reg_start,
  // straps and decoded configuration
  input wire sca_pkg::sca_straps_t straps,
  output sca_pkg::sca_modes_t modes,
  // system pins
  output logic system_reset_n,
  output logic ext_supply_enable,
  input wire logic ext_supply_good,
  output logic power_ok_pin,
  // software open-drain pin
  input wire logic sw_pin_i,
  output logic sw_pin_o,
  output logic sw_pin_oe
);

  sca_pkg::sca_state_t s_r;
  sca_pkg::sca_state_t s_nxt;

  logic [`SCA_NREG-1:0] tmr_done;
  logic ext_done;
  logic ext_run;
  logic [`SCA_CNT_W-1:0] ext_target;

  // extra delay code to ticks of 0.25 ms
  function automatic logic [5:0] extra_ticks(input logic [1:0] code);
    extra_ticks = 6'(code * `SCA_EXTRA_STEP);
  endfunction

  // external enable delay code to ticks: 0 .. 1 ms then 2, 4 and 8 ms
  function automatic logic [5:0] ext_ticks(input logic [2:0] code);
    logic [5:0] t;
    t = 6'h00;
    unique case (code)
      3'h0: t = 6'h00;
      3'h1: t = 6'h01;
      3'h2: t = 6'h02;
      3'h3: t = 6'h03;
      3'h4: t = 6'h04;
      3'h5: t = 6'h08;
      3'h6: t = 6'h10;
      3'h7: t = 6'h20;
    endcase
    ext_ticks = t;
  endfunction

  // pick one power_ok flag; codes past the last regulator give low
  function automatic logic pick_ok(input logic [5:0] ok, input logic [2:0] sel);
    pick_ok = (sel < 3'h6) ? ok[sel] : 1'b0;
  endfunction

  // strap pin state to voltage setting 0, 1 or 2
  function automatic logic [1:0] lvl_vsel(input sca_pkg::sca_lvl3_t lvl);
    logic [1:0] v;
    v = 2'h0;
    unique case (lvl)
      sca_pkg::LVL_HIGH: v = 2'h0;
      sca_pkg::LVL_FLOAT: v = 2'h1;
      sca_pkg::LVL_LOW: v = 2'h2;
      default: v = 2'h0;
    endcase
    lvl_vsel = v;
  endfunction

  // decode all straps into modes and voltage settings
  function automatic sca_pkg::sca_modes_t decode(input sca_pkg::sca_straps_t p,
                                                 input sca_pkg::sca_strap_cfg_t c);
    sca_pkg::sca_modes_t m;
    sca_pkg::sca_lvl3_t b4_pin;
    m = '0;
    b4_pin = p.b4;
    m.b1_load_switch_mode = (p.b1 == sca_pkg::LVL_HIGH);
    m.b1_vsel = (p.b1 == sca_pkg::LVL_LOW);
    if (c.shared_strap_b1b2_en)
    begin
      if (p.b1 == sca_pkg::LVL_LOW)
      begin
        m.b2_vsel = c.b2_voltage_choice_strap_low;
      end
      else
      begin
        m.b2_vsel = c.b2_voltage_choice;
      end
    end
    else
    begin
      m.b2_vsel = !p.b2_high;
    end
    m.b3_vsel = lvl_vsel(p.b3);
    if (c.shared_strap_l1b4_en)
    begin
      b4_pin = p.l1;
    end
    m.l1_load_switch_mode = (p.l1 == sca_pkg::LVL_FLOAT);
    m.l1_vsel = (p.l1 == sca_pkg::LVL_LOW);
    if (c.shared_strap_l1b4_en)
    begin
      if (b4_pin == sca_pkg::LVL_FLOAT)
      begin
        m.b4_linear = !c.b4_regulator_type;
        m.b4_vsel = c.b4_regulator_type ? 2'h1 : 2'h2;
      end
      else
      begin
        m.b4_linear = 1'b0;
        m.b4_vsel = 2'h0;
      end
    end
    else
    begin
      m.b4_linear = (b4_pin == sca_pkg::LVL_LOW);
      m.b4_vsel = lvl_vsel(b4_pin);
    end
    m.l2_load_switch_mode = !p.l2_high;
    decode = m;
  endfunction

  // register read mux
  function automatic logic [15:0] read_reg(input sca_pkg::sca_state_t s,
                                           input logic [3:0] a,
                                           input logic [5:0] ok,
                                           input logic pin_in);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      `SCA_A_RST_INCL: d = {7'h00, s.mask_off, 2'h0, s.incl};
      `SCA_A_REG_CMD: d = {10'h000, s.cmd};
      `SCA_A_EXT_CFG: d = {5'h00, s.pg_tgt, 1'b0, s.ext_fn, s.ext_dly, s.ext_src};
      `SCA_A_PIN_CFG: d = {11'h000, s.sw_lvl, 1'b0, s.ok_pin_sel};
      `SCA_A_STRAP_CFG: d = {11'h000, s.scfg};
      `SCA_A_DLY_HIGH: d = {10'h000, s.dly_hi};
      `SCA_A_DLY_FLOAT: d = {10'h000, s.dly_fl};
      `SCA_A_DLY_LOW: d = {10'h000, s.dly_lo};
      `SCA_A_START_A: d = {4'h0, s.start_dly[11:0]};
      `SCA_A_START_B: d = {4'h0, s.start_dly[23:12]};
      `SCA_A_STATUS: d = {s.reg_start, s.latched, pin_in, s.ext_on, s.rst_n, ok};
      `SCA_A_STRAP_STAT: d = {5'h00, s.modes};
      default: d = 16'h0000;
    endcase
    read_reg = d;
  endfunction

  // per-regulator start timers: normal start delay, plus extra delay for regulators 3 to 5 only
  generate
    for (genvar i = 0; i < `SCA_NREG; i++)
    begin : g_tmr
      logic [`SCA_CNT_W-1:0] tgt;
      if (i >= `SCA_IDX_B4)
      begin : g_extra
        assign tgt = 6'({2'h0, s_r.start_dly[i*4 +: 4]}
                        + extra_ticks(s_r.extra[(i-`SCA_IDX_B4)*2 +: 2]));
      end
      else
      begin : g_plain
        assign tgt = {2'h0, s_r.start_dly[i*4 +: 4]};
      end
      sca_delay_timer u_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .tick_cycles(TICK_CYCLES),
        .run(s_r.trg[i]),
        .target(tgt),
        .done(tmr_done[i])
      );
    end
  endgenerate

  // external supply enable delay
  // delay after power_ok
  assign ext_run = s_r.ext_fn & pick_ok(power_ok, s_r.ext_src);
  assign ext_target = ext_ticks(s_r.ext_dly);

  sca_delay_timer u_ext_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .tick_cycles(TICK_CYCLES),
    .run(ext_run),
    .target(ext_target),
    .done(ext_done)
  );

  // next-state logic: registers, sequencing and pins
  always_comb
  begin
    logic [5:0] contrib;
    logic [5:0] sel_dly;
    logic [5:0] trig_now;
    contrib = 6'h00;
    sel_dly = 6'h00;
    trig_now = 6'h00;
    s_nxt = s_r;

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SCA_A_RST_INCL:
        begin
          s_nxt.incl = reg_wdata[5:0];
          s_nxt.mask_off = reg_wdata[`SCA_F_MASK_OFF];
        end
        `SCA_A_REG_CMD: s_nxt.cmd = reg_wdata[5:0];
        `SCA_A_EXT_CFG:
        begin
          s_nxt.ext_src = reg_wdata[2:0];
          s_nxt.ext_dly = reg_wdata[`SCA_F_EXT_DLY +: 3];
          s_nxt.ext_fn = reg_wdata[`SCA_F_EXT_FN];
          s_nxt.pg_tgt = reg_wdata[`SCA_F_PG_TGT +: 3];
        end
        `SCA_A_PIN_CFG:
        begin
          s_nxt.ok_pin_sel = reg_wdata[2:0];
          s_nxt.sw_lvl = reg_wdata[`SCA_F_SW_LVL];
        end
        `SCA_A_STRAP_CFG: s_nxt.scfg = sca_pkg::sca_strap_cfg_t'(reg_wdata[4:0]);
        `SCA_A_DLY_HIGH: s_nxt.dly_hi = reg_wdata[5:0];
        `SCA_A_DLY_FLOAT: s_nxt.dly_fl = reg_wdata[5:0];
        `SCA_A_DLY_LOW: s_nxt.dly_lo = reg_wdata[5:0];
        `SCA_A_START_A: s_nxt.start_dly[11:0] = reg_wdata[11:0];
        `SCA_A_START_B: s_nxt.start_dly[23:12] = reg_wdata[11:0];
        default: s_nxt.incl = s_r.incl;
      endcase
    end

    // read data stands for the cycle after the strobe only
    s_nxt.rdata = reg_rd ? read_reg(s_r, reg_addr, power_ok, sw_pin_i) : 16'h0000;

    // start triggers: the selected regulator waits for the external good
    for (int i = 0; i < `SCA_NREG; i++)
    begin
      trig_now[i] = (s_r.pg_tgt == 3'(i)) ? ext_supply_good : 1'b1;
    end

    // extra delay set chosen by the buck3 strap level
    // strap selects delays
    unique case (straps.b3)
      sca_pkg::LVL_HIGH: sel_dly = s_r.dly_hi;
      sca_pkg::LVL_FLOAT: sel_dly = s_r.dly_fl;
      sca_pkg::LVL_LOW: sel_dly = s_r.dly_lo;
      default: sel_dly = s_r.dly_fl;
    endcase

    // power-up sequence
    unique case (s_r.seq)
      sca_pkg::SEQ_OFF:
      begin
        s_nxt.trg = 6'h00;
        s_nxt.reg_start = 6'h00;
        if (power_up_req)
        begin
          s_nxt.modes = decode(straps, s_r.scfg);
          s_nxt.extra = sel_dly;
          s_nxt.latched = 1'b1;
          s_nxt.seq = sca_pkg::SEQ_RUN;
        end
      end
      sca_pkg::SEQ_RUN:
      begin
        if (!power_up_req)
        begin
          s_nxt.trg = 6'h00;
          s_nxt.reg_start = 6'h00;
          s_nxt.seq = sca_pkg::SEQ_OFF;
        end
        else
        begin
          s_nxt.trg = s_r.trg | trig_now;
          s_nxt.reg_start = tmr_done & s_r.cmd;
        end
      end
    endcase

    // reset aggregation
    // per-regulator inclusion
    contrib = s_r.incl & (s_r.mask_off ? s_r.cmd : 6'h3f);
    s_nxt.rst_n = ~|(contrib & ~power_ok);

    // external supply enable: held while the source stays ok
    s_nxt.ext_on = ext_run & ext_done;

    s_nxt.ok_pin = pick_ok(power_ok, s_r.ok_pin_sel);

    s_nxt.sw_oe = !s_r.sw_lvl;
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.seq <= sca_pkg::SEQ_OFF;
      s_r.incl <= `SCA_RV_INCL;
      s_r.mask_off <= `SCA_RV_MASK_OFF;
      s_r.cmd <= `SCA_RV_CMD;
      s_r.ext_src <= `SCA_RV_EXT_SRC;
      s_r.ext_dly <= `SCA_RV_EXT_DLY;
      s_r.ext_fn <= `SCA_RV_EXT_FN;
      s_r.pg_tgt <= `SCA_RV_PG_TGT;
      s_r.ok_pin_sel <= `SCA_RV_OK_PIN_SEL;
      s_r.sw_lvl <= `SCA_RV_SW_LVL;
      s_r.scfg <= `SCA_RV_STRAP_CFG;
      s_r.dly_hi <= `SCA_RV_DLY_HIGH;
      s_r.dly_fl <= `SCA_RV_DLY_FLOAT;
      s_r.dly_lo <= `SCA_RV_DLY_LOW;
      s_r.start_dly <= `SCA_RV_START;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_r.rdata;
  assign reg_start = s_r.reg_start;
  assign modes = s_r.modes;
  assign system_reset_n = s_r.rst_n;
  assign ext_supply_enable = s_r.ext_on;
  assign power_ok_pin = s_r.ok_pin;
  assign sw_pin_oe = s_r.sw_oe;
  // open drain only ever drives low
  assign sw_pin_o = 1'b0;

endmodule

// ==== shared/sca_defines.svh ====
// constants for the strap configuration and reset aggregator
`ifndef SCA_DEFINES_SVH
`define SCA_DEFINES_SVH

// clock and time base
`define SCA_CLK_MHZ 50
`define SCA_TICK_US 250
`define SCA_TICK_CYCLES 16'(`SCA_TICK_US * `SCA_CLK_MHZ)
`define SCA_TICK_W 16
`define SCA_CNT_W 6

// regulator count and indices
`define SCA_NREG 6
`define SCA_IDX_B4 3
`define SCA_IDX_NONE 3'h7

// register port widths
`define SCA_ADDR_W 4
`define SCA_DATA_W 16

// register addresses
`define SCA_A_RST_INCL 4'h0
`define SCA_A_REG_CMD 4'h1
`define SCA_A_EXT_CFG 4'h2
`define SCA_A_PIN_CFG 4'h3
`define SCA_A_STRAP_CFG 4'h4
`define SCA_A_DLY_HIGH 4'h5
`define SCA_A_DLY_FLOAT 4'h6
`define SCA_A_DLY_LOW 4'h7
`define SCA_A_START_A 4'h8
`define SCA_A_START_B 4'h9
`define SCA_A_STATUS 4'ha
`define SCA_A_STRAP_STAT 4'hb

// field positions
`define SCA_F_MASK_OFF 8
`define SCA_F_EXT_DLY 3
`define SCA_F_EXT_FN 6
`define SCA_F_PG_TGT 8
`define SCA_F_SW_LVL 4

// reset values
`define SCA_RV_INCL 6'h3f
`define SCA_RV_MASK_OFF 1'b1
`define SCA_RV_CMD 6'h3f
`define SCA_RV_EXT_SRC 3'h0
`define SCA_RV_EXT_DLY 3'h0
`define SCA_RV_EXT_FN 1'b0
`define SCA_RV_PG_TGT 3'h7
`define SCA_RV_OK_PIN_SEL 3'h0
`define SCA_RV_SW_LVL 1'b1
`define SCA_RV_STRAP_CFG 5'h00
`define SCA_RV_DLY_HIGH 6'h17
`define SCA_RV_DLY_FLOAT 6'h00
`define SCA_RV_DLY_LOW 6'h07
`define SCA_RV_START 24'h000000

// extra delay step, in ticks of 0.25 ms (0.75 ms)
`define SCA_EXTRA_STEP 6'h03

`endif

// ==== shared/sca_pkg.sv ====
// types for the strap configuration and reset aggregator
package sca_pkg;

  // resolved level of a three-level strap
  typedef enum logic [1:0] {LVL_HIGH, LVL_FLOAT, LVL_LOW} sca_lvl3_t;

  // power-up sequence phase
  typedef enum logic [0:0] {SEQ_OFF, SEQ_RUN} sca_seq_t;

  // strap pins, already resolved by the level comparators
  typedef struct packed {
    sca_lvl3_t b1;
    logic b2_high;
    sca_lvl3_t b3;
    sca_lvl3_t b4;
    sca_lvl3_t l1;
    logic l2_high;
  } sca_straps_t;

  // stored strap options
  typedef struct packed {
    logic b4_regulator_type;
    logic shared_strap_l1b4_en;
    logic b2_voltage_choice_strap_low;
    logic b2_voltage_choice;
    logic shared_strap_b1b2_en;
  } sca_strap_cfg_t;

  // decoded regulator modes and voltage settings
  typedef struct packed {
    logic l2_load_switch_mode;
    logic l1_vsel;
    logic l1_load_switch_mode;
    logic [1:0] b4_vsel;
    logic b4_linear;
    logic [1:0] b3_vsel;
    logic b2_vsel;
    logic b1_vsel;
    logic b1_load_switch_mode;
  } sca_modes_t;

  // delay timer state
  typedef struct packed {
    logic [15:0] pre;
    logic [5:0] cnt;
    logic done;
  } sca_tmr_state_t;

  // aggregator state
  typedef struct packed {
    sca_seq_t seq;
    logic [5:0] incl;
    logic mask_off;
    logic [5:0] cmd;
    logic [2:0] ext_src;
    logic [2:0] ext_dly;
    logic ext_fn;
    logic [2:0] pg_tgt;
    logic [2:0] ok_pin_sel;
    logic sw_lvl;
    sca_strap_cfg_t scfg;
    logic [5:0] dly_hi;
    logic [5:0] dly_fl;
    logic [5:0] dly_lo;
    logic [23:0] start_dly;
    sca_modes_t modes;
    logic [5:0] extra;
    logic latched;
    logic [5:0] trg;
    logic [5:0] reg_start;
    logic [15:0] rdata;
    logic rst_n;
    logic ext_on;
    logic ok_pin;
    logic sw_oe;
  } sca_state_t;

endpackage

// ==== verilog/sca_delay_timer.sv ====
// delay timer counting whole ticks while its run level is high
`timescale 1ns/1ns
`include "sca_defines.svh"

module sca_delay_timer (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // tick length in clock cycles
  input wire logic [`SCA_TICK_W-1:0] tick_cycles,
  // control
  input wire logic run,
  input wire logic [`SCA_CNT_W-1:0] target,
  // result
  output logic done
);

  sca_pkg::sca_tmr_state_t s_r;
  sca_pkg::sca_tmr_state_t s_nxt;

  // count ticks while running; dropping run restarts the delay
  always_comb
  begin
    s_nxt = s_r;
    if (!run)
    begin
      s_nxt = '0;
    end
    else if (s_r.cnt >= target)
    begin
      s_nxt.done = 1'b1;
    end
    else if (s_r.pre == 16'(tick_cycles - 16'h0001))
    begin
      s_nxt.pre = 16'h0000;
      s_nxt.cnt = 6'(s_r.cnt + 6'h01);
    end
    else
    begin
      s_nxt.pre = 16'(s_r.pre + 16'h0001);
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;

endmodule

// ==== tb/sca_top_asserts.sv ====
// port assertions for the strap and reset aggregator
`timescale 1ns/1ns
`include "sca_defines.svh"

module sca_top_asserts #(
  parameter logic [`SCA_TICK_W-1:0] TICK_CYCLES = `SCA_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [`SCA_ADDR_W-1:0] reg_addr,
  input wire logic [`SCA_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SCA_DATA_W-1:0] reg_rdata,
  // sequencing and pins
  input wire logic [`SCA_NREG-1:0] power_ok,
  input wire logic power_up_req,
  input wire logic [`SCA_NREG-1:0] reg_start,
  input wire sca_pkg::sca_modes_t modes,
  input wire logic system_reset_n,
  input wire logic sw_pin_o,
  input wire logic sw_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !ce);

  // one pin-level write followed by a quiet cycle
  sequence s_sw_write;
    reg_wr && reg_addr == 4'h3 ##1 !(reg_wr && reg_addr == 4'h3);
  endsequence
  // a fresh power-up request
  sequence s_req_rise;
    $rose(power_up_req);
  endsequence

  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  a_pin_drive_low: assert property (sw_pin_oe |-> sw_pin_o == 1'b0)
    else $error("open-drain pin drives high");
  a_pin_oe_quiet: assert property (!$past(reg_wr, 2) |-> $stable(sw_pin_oe))
    else $error("pin enable moved without a write");
  a_sw_level_follow: assert property (s_sw_write |=> sw_pin_oe == !$past(reg_wdata[4], 2))
    else $error("pin enable not from written level");
  a_all_ok_release: assert property (&power_ok |=> system_reset_n)
    else $error("reset held with all rails ok");
  a_start_needs_req: assert property (!$past(power_up_req) |-> reg_start == '0)
    else $error("start without request");
  a_start_not_early: assert property (s_req_rise |-> reg_start == '0 ##1 reg_start == '0)
    else $error("start too early");
  a_modes_held: assert property ($past(power_up_req, 2) && $past(power_up_req)
    && power_up_req |-> $stable(modes))
    else $error("modes changed while running");
  a_status_read: assert property (reg_rd && reg_addr == 4'ha |=>
    reg_rdata[5:0] == $past(power_ok) && reg_rdata[6] == $past(system_reset_n)
    && reg_rdata[15:10] == $past(reg_start))
    else $error("status word wrong");
endmodule

bind sca_top sca_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_sca_top_asserts (
  .clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_ok(power_ok),
  .power_up_req(power_up_req), .reg_start(reg_start), .modes(modes),
  .system_reset_n(system_reset_n), .sw_pin_o(sw_pin_o), .sw_pin_oe(sw_pin_oe)
);

// ==== tb/sca_far_side.sv ====
// rails, external supply and pull-up facing the aggregator
`timescale 1ns/1ns

module sca_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // rail enables, forced faults, flags
  input wire logic [5:0] reg_start,
  input wire logic [5:0] kill,
  output logic [5:0] power_ok,
  // external supply
  input wire logic ext_supply_enable,
  output logic ext_supply_good,
  // open-drain pin
  input wire logic sw_pin_o,
  input wire logic sw_pin_oe,
  output logic sw_pin_i
);
  logic [11:0] rail_q;
  logic [2:0] ext_q;
  // rails settle two cycles after start, supply three after enable
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rail_q <= '0;
      ext_q <= '0;
    end
    else
    begin
      rail_q <= {rail_q[5:0], reg_start};
      ext_q <= {ext_q[1:0], ext_supply_enable};
    end
  end
  assign power_ok = rail_q[11:6] & ~kill;
  assign ext_supply_good = ext_q[2];
  // pull-up when nobody pulls low
  assign sw_pin_i = sw_pin_oe ? sw_pin_o : 1'b1;
endmodule

// ==== tb/tb_sca_top.sv ====
// self-checking bench for the strap and reset aggregator
`timescale 1ns/1ns

module tb_sca_top;
  localparam logic [15:0] TICK = 16'h0004;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic power_up_req = 1'b0;
  logic [5:0] kill = 6'h00;
  sca_pkg::sca_straps_t straps = '0;
  logic [15:0] reg_rdata, d;
  logic [5:0] power_ok, reg_start;
  logic ext_supply_enable, ext_supply_good, power_ok_pin, system_reset_n;
  logic sw_pin_i, sw_pin_o, sw_pin_oe;
  sca_pkg::sca_modes_t modes, e;
  int fail_count = 0;
  int samples_checked = 0;
  int t_st [6];
  int t_ext;
  logic [5:0] dv [3] = '{6'h17, 6'h00, 6'h07};
  logic [4:0] cfgs [5] = '{5'h00, 5'h03, 5'h05, 5'h18, 5'h08};
  int stt [6] = '{0, 1, 3, 1, 2, 0};
  int dt [8] = '{0, 1, 2, 3, 4, 8, 16, 32};
  logic [15:0] rv [10] = '{16'h013f, 16'h003f, 16'h0700, 16'h0010, 16'h0000, 16'h0017,
    16'h0000, 16'h0007, 16'h0000, 16'h0000};

  always #10 clk = ~clk;

  sca_top #(.TICK_CYCLES(TICK)) i_sca_top (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_ok(power_ok),
    .power_up_req(power_up_req), .reg_start(reg_start), .straps(straps), .modes(modes),
    .system_reset_n(system_reset_n), .ext_supply_enable(ext_supply_enable),
    .ext_supply_good(ext_supply_good), .power_ok_pin(power_ok_pin), .sw_pin_i(sw_pin_i),
    .sw_pin_o(sw_pin_o), .sw_pin_oe(sw_pin_oe)
  );
  sca_far_side i_sca_far_side (
    .clk(clk), .rst_b(rst_b), .reg_start(reg_start), .kill(kill), .power_ok(power_ok),
    .ext_supply_enable(ext_supply_enable), .ext_supply_good(ext_supply_good),
    .sw_pin_o(sw_pin_o), .sw_pin_oe(sw_pin_oe), .sw_pin_i(sw_pin_i)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // drop the request long enough for every output to fall, then raise it
  task automatic req_pulse();
    @(posedge clk);
    power_up_req <= 1'b0;
    wait_cyc(8);
    @(posedge clk);
    power_up_req <= 1'b1;
  endtask
  // start a sequence and note the first cycle each output rises
  task automatic run_seq();
    req_pulse();
    t_st = '{default: -1};
    t_ext = -1;
    for (int k = 1; k <= 300; k++)
    begin
      wait_cyc(1);
      for (int i = 0; i < 6; i++)
        if (t_st[i] < 0 && reg_start[i] === 1'b1)
          t_st[i] = k;
      if (t_ext < 0 && ext_supply_enable === 1'b1)
        t_ext = k;
    end
  endtask
  task automatic results();
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // same level on every strap; two-level pins low only for the low case
  function automatic sca_pkg::sca_straps_t st_of(input int l);
    logic [1:0] v;
    v = 2'(l);
    return {v, v != 2'h2, v, v, v, v != 2'h2};
  endfunction
  // decoded modes expected for a strap level and stored options
  function automatic sca_pkg::sca_modes_t exp_m(input int l, input logic [4:0] c);
    sca_pkg::sca_modes_t m;
    m = '0;
    m.b1_load_switch_mode = (l == 0);
    m.b1_vsel = (l == 2);
    m.b2_vsel = c[0] ? ((l == 2) ? c[2] : c[1]) : (l == 2);
    m.b3_vsel = 2'(l);
    m.b4_vsel = c[3] ? ((l == 1) ? (c[4] ? 2'h1 : 2'h2) : 2'h0) : 2'(l);
    m.b4_linear = c[3] ? (l == 1 && !c[4]) : (l == 2);
    m.l1_load_switch_mode = (l == 1);
    m.l1_vsel = (l == 2);
    m.l2_load_switch_mode = (l == 2);
    return m;
  endfunction
  // strap-picked extra ticks for the three delayed rails
  function automatic int ex(input int l, input int i);
    return (i < 3) ? 0 : 3 * int'((dv[l] >> (2 * (i - 3))) & 6'h03);
  endfunction

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // reset values and an unmapped address
    for (int a = 0; a < 10; a++)
    begin
      rd((a == 9) ? 4'hc : 4'(a), d);
      chk(d, rv[a]);
    end
    // strap decode for each level and shared option, then latch hold
    foreach (cfgs[c])
      for (int l = 0; l < 3; l++)
      begin
        wr(4'h4, 16'(cfgs[c]));
        straps <= st_of(l);
        req_pulse();
        wait_cyc(4);
        e = exp_m(l, cfgs[c]);
        chk(16'(modes), 16'(e));
        @(posedge clk) straps <= st_of((l + 1) % 3);
        rd(4'hb, d);
        chk(d, 16'(e));
      end
    // start delay plus strap-picked extra delay
    wr(4'h8, 16'h0310);
    wr(4'h9, 16'h0021);
    for (int l = 0; l < 3; l++)
    begin
      @(posedge clk) straps <= st_of(l);
      run_seq();
      for (int i = 1; i < 6; i++)
        chk(16'(t_st[i] - t_st[0]), 16'(stt[i] + ex(l, i)) * TICK);
    end
    // external enable delay codes; external good starts the third rail
    for (int c = 0; c < 8; c++)
    begin
      wr(4'h2, 16'h0240 | 16'(c << 3));
      run_seq();
      if (c == 0)
        d = 16'(t_ext);
      chk(16'(t_ext) - d, 16'(dt[c]) * TICK);
      chk(16'(t_st[2] > t_ext + 3), 16'h0001);
    end
    wr(4'h2, 16'h0700);
    run_seq();
    // reset aggregation, inclusion and routed flags
    chk(16'(system_reset_n), 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      wr(4'h3, 16'h0010 | 16'(i));
      kill <= 6'(1 << i);
      wait_cyc(3);
      chk(16'(system_reset_n), 16'h0000);
      chk(16'(power_ok_pin), 16'h0000);
      wr(4'h0, 16'h013f & ~16'(1 << i));
      wait_cyc(2);
      chk(16'(system_reset_n), 16'h0001);
      wr(4'h0, 16'h013f);
      kill <= 6'h00;
      wait_cyc(3);
      chk(16'(power_ok_pin), 16'h0001);
    end
    // a commanded-off rail is masked unless masking is turned off
    wr(4'h1, 16'h002f);
    wait_cyc(6);
    chk(16'(system_reset_n), 16'h0001);
    wr(4'h0, 16'h003f);
    wait_cyc(2);
    chk(16'(system_reset_n), 16'h0000);
    wr(4'h0, 16'h013f);
    wr(4'h1, 16'h003f);
    // software open-drain pin pulled low, then released
    wr(4'h3, 16'h0000);
    wait_cyc(2);
    chk(16'(sw_pin_oe), 16'h0001);
    rd(4'ha, d);
    chk(16'(d[8]), 16'h0000);
    wr(4'h3, 16'h0010);
    wait_cyc(2);
    chk(16'(sw_pin_oe), 16'h0000);
    results();
  end
endmodule
